// File: core/ppst_pkg.sv
// constants, types and field layouts of the port power status tracker
package ppst_pkg;

    localparam int          NUM_PORTS             = 4;
    localparam logic [7:0]  ADDR_PORT_POWER_FLAGS = 8'h10;
    localparam int          PG_LSB                = 4;
    localparam int          FET_LSB               = 0;
    localparam logic [7:0]  PORT_POWER_FLAGS_RST  = 8'h00;
    localparam logic [7:0]  UNMAPPED_READ         = 8'h00;

    typedef enum logic [1:0] {
        MODE_SHUTDOWN = 2'b00,
        MODE_MANUAL   = 2'b01,
        MODE_SEMI     = 2'b10,
        MODE_AUTO     = 2'b11
    } ppst_mode_e;

    localparam logic [3:0]  CLS_NONE     = 4'h0;
    localparam logic [3:0]  CLS_CLASS4   = 4'h4;
    localparam logic [3:0]  CLS_T1LIM    = 4'hC;
    localparam logic [3:0]  CLS_LEGACY5  = 4'hD;
    localparam logic [3:0]  CLS_MISMATCH = 4'hF;

    localparam longint      CLK_HZ          = 50_000_000;
    localparam longint      TICK_US         = 1000;
    localparam int          TICK_CYCLES     = int'((CLK_HZ / 1_000_000) * TICK_US);
    localparam int          INRUSH_MS_DFLT  = 60;
    localparam int          CNT_W           = 16;

    typedef enum logic [2:0] {
        PST_OFF    = 3'b000,
        PST_WAIT   = 3'b001,
        PST_DET    = 3'b010,
        PST_CLS    = 3'b011,
        PST_CRST   = 3'b100,
        PST_INRUSH = 3'b101,
        PST_PGOOD  = 3'b110
    } ppst_pst_e;

    typedef struct packed {
        ppst_pst_e        st;
        logic             pwron;
        logic             fet;
        logic             pg;
        logic             mon;
        logic [3:0]       cls;
        logic [CNT_W-1:0] cnt;
    } ppst_port_s;

    typedef struct packed {
        logic       det_start;
        logic       cls_start;
        logic       cls_pwron;
        logic       cls_reset;
        logic [1:0] port;
    } ppst_eng_req_s;

    typedef struct packed {
        logic       det_done;
        logic       valid_signature_result;
        logic       cls_done;
        logic [3:0] cls_code;
    } ppst_eng_rsp_s;

    typedef struct packed {
        logic                 busy;
        logic [1:0]           idx;
        logic [1:0]           rr;
        logic [NUM_PORTS-1:0] grant;
        logic [CNT_W-1:0]     div;
        logic                 tick;
    } ppst_arb_s;

endpackage

// File: core/ppst_arb.sv
// shared engine arbiter and millisecond tick divider
`timescale 1ns/10ps
module ppst_arb #(
    parameter int TICK_CYCLES = ppst_pkg::TICK_CYCLES
) (
    input  wire logic                           i_core_clk,
    input  wire logic                           i_srst,
    input  wire logic [ppst_pkg::NUM_PORTS-1:0] i_req,
    output logic      [ppst_pkg::NUM_PORTS-1:0] o_grant,
    output logic                                o_tick
);

    ppst_pkg::ppst_arb_s r, n;

    localparam logic [ppst_pkg::CNT_W-1:0] CNT_LAST = ppst_pkg::CNT_W'(TICK_CYCLES - 1);

    always_comb begin
        logic       found;
        logic [1:0] cand;
        found = 1'b0;
        cand  = 2'b00;
        n     = r;
        n.tick = 1'b0;
        if (r.div == CNT_LAST) begin
            n.div  = '0;
            n.tick = 1'b1;
        end else begin
            n.div = r.div + 1'b1;
        end
        // one port served at a time
        if (r.busy) begin
            if (!i_req[r.idx]) begin
                n.busy  = 1'b0;
                n.grant = '0;
            end
        end else begin
            // round robin so no port starves behind another
            for (int k = 1; k <= ppst_pkg::NUM_PORTS; k++) begin
                cand = r.rr + k[1:0];
                if (!found && i_req[cand]) begin
                    found = 1'b1;
                    n.busy = 1'b1;
                    n.idx  = cand;
                    n.rr   = cand;
                    n.grant = '0;
                    n.grant[cand] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign o_grant = r.grant;
    assign o_tick  = r.tick;

endmodule

// File: core/ppst_top.sv
// four-port power-up sequencer with status flags and change indications
`timescale 1ns/10ps
module ppst_top #(
    parameter int TICK_CYCLES       = ppst_pkg::TICK_CYCLES,
    parameter int inrush_interval   = ppst_pkg::INRUSH_MS_DFLT
) (
    input  wire logic                               i_core_clk,
    input  wire logic                               i_srst,
    input  wire logic [2*ppst_pkg::NUM_PORTS-1:0]   i_port_operating_mode_field,
    input  wire logic [ppst_pkg::NUM_PORTS-1:0]     i_host_power_on_request,
    input  wire logic [ppst_pkg::NUM_PORTS-1:0]     i_host_power_off_request,
    input  wire logic [ppst_pkg::NUM_PORTS-1:0]     i_probe_enable,
    input  wire logic [ppst_pkg::NUM_PORTS-1:0]     i_legacy5_select,
    input  wire logic [ppst_pkg::NUM_PORTS-1:0]     i_drain_low,
    input  wire logic [ppst_pkg::NUM_PORTS-1:0]     i_current_limit_fault,
    input  wire logic [ppst_pkg::NUM_PORTS-1:0]     i_power_cut_fault,
    input  wire logic [ppst_pkg::NUM_PORTS-1:0]     i_disconnect,
    input  wire ppst_pkg::ppst_eng_rsp_s            i_eng_rsp,
    input  wire logic [ppst_pkg::NUM_PORTS-1:0]     i_class_finished_clr,
    input  wire logic [ppst_pkg::NUM_PORTS-1:0]     i_fet_chg_clr,
    input  wire logic [ppst_pkg::NUM_PORTS-1:0]     i_pg_chg_clr,
    input  wire logic                               i_rd_en,
    input  wire logic [7:0]                         i_rd_addr,
    output ppst_pkg::ppst_eng_req_s                 o_eng_req,
    output logic      [ppst_pkg::NUM_PORTS-1:0]     o_fet_on_flag,
    output logic      [ppst_pkg::NUM_PORTS-1:0]     o_port_powered_flag,
    output logic      [ppst_pkg::NUM_PORTS-1:0]     o_monitor_active,
    output logic      [4*ppst_pkg::NUM_PORTS-1:0]   o_class_result_field,
    output logic      [ppst_pkg::NUM_PORTS-1:0]     o_class_finished_flag,
    output logic      [ppst_pkg::NUM_PORTS-1:0]     o_fet_chg,
    output logic      [ppst_pkg::NUM_PORTS-1:0]     o_pg_chg,
    output logic      [7:0]                         o_rd_data,
    output logic                                    o_rd_valid
);

    localparam int NP = ppst_pkg::NUM_PORTS;
    localparam logic [ppst_pkg::CNT_W-1:0] INRUSH_LAST = ppst_pkg::CNT_W'(inrush_interval - 1);

    typedef struct packed {
        ppst_pkg::ppst_port_s [NP-1:0] port;
        logic [NP-1:0]                 req;
        logic [NP-1:0]                 cls_fin;
        logic [NP-1:0]                 fet_chg;
        logic [NP-1:0]                 pg_chg;
        ppst_pkg::ppst_eng_req_s       eng;
        logic [7:0]                    rd_data;
        logic                          rd_valid;
    } ppst_top_s;

    ppst_top_s      r, n;
    logic [NP-1:0]  grant;
    logic           tick;

    ppst_arb #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_arb (
        .i_core_clk (i_core_clk),
        .i_srst     (i_srst),
        .i_req      (r.req),
        .o_grant    (grant),
        .o_tick     (tick)
    );

    // reported class code after filtering
    function automatic logic [3:0] filt_class(input logic [3:0] code, input logic legacy5, input logic pwron);
        logic [3:0] res;
        res = code;
        if (code == ppst_pkg::CLS_LEGACY5 && !legacy5) begin
            res = ppst_pkg::CLS_CLASS4;
        end
        if (code == ppst_pkg::CLS_T1LIM && !pwron) begin
            res = ppst_pkg::CLS_CLASS4;
        end
        return res;
    endfunction

    always_comb begin
        ppst_pkg::ppst_port_s ps;
        ppst_pkg::ppst_mode_e mode;
        logic                 fault;
        logic                 turn_off;
        logic                 cls_new;
        logic [7:0]           flags;
        ps       = '0;
        mode     = ppst_pkg::MODE_SHUTDOWN;
        fault    = 1'b0;
        turn_off = 1'b0;
        cls_new  = 1'b0;
        flags    = ppst_pkg::PORT_POWER_FLAGS_RST;
        n          = r;
        n.eng      = '0;
        n.rd_valid = i_rd_en;
        // every port runs on its own slice
        for (int p = 0; p < NP; p++) begin
            ps       = r.port[p];
            mode     = ppst_pkg::ppst_mode_e'(i_port_operating_mode_field[2*p +: 2]);
            fault    = i_current_limit_fault[p] | i_power_cut_fault[p] | i_disconnect[p];
            turn_off = 1'b0;
            cls_new  = 1'b0;
            if (mode == ppst_pkg::MODE_SHUTDOWN) begin
                turn_off = 1'b1;
                ps.cls   = ppst_pkg::CLS_NONE;
            end else begin
                unique case (r.port[p].st)
                    ppst_pkg::PST_OFF: begin
                        // manual mode is debug only and never starts a sequence here
                        if ((i_host_power_on_request[p] && mode != ppst_pkg::MODE_MANUAL) ||
                            mode == ppst_pkg::MODE_AUTO) begin
                            ps.pwron = 1'b1;
                            ps.st    = ppst_pkg::PST_WAIT;
                        end else if (i_probe_enable[p] && mode == ppst_pkg::MODE_SEMI) begin
                            ps.pwron = 1'b0;
                            ps.st    = ppst_pkg::PST_WAIT;
                        end
                    end
                    ppst_pkg::PST_WAIT: begin
                        if (grant[p]) begin
                            n.eng.det_start = 1'b1;
                            n.eng.port      = p[1:0];
                            ps.st           = ppst_pkg::PST_DET;
                        end
                    end
                    ppst_pkg::PST_DET: begin
                        if (i_eng_rsp.det_done) begin
                            // classify only on a good signature
                            if (i_eng_rsp.valid_signature_result) begin
                                n.eng.cls_start = 1'b1;
                                n.eng.cls_pwron = ps.pwron;
                                n.eng.port      = p[1:0];
                                ps.st           = ppst_pkg::PST_CLS;
                            end else begin
                                ps.st = ppst_pkg::PST_OFF;
                            end
                        end
                    end
                    ppst_pkg::PST_CLS: begin
                        if (i_eng_rsp.cls_done) begin
                            if (i_eng_rsp.cls_code == ppst_pkg::CLS_MISMATCH) begin
                                n.eng.cls_reset = 1'b1;
                                n.eng.port      = p[1:0];
                                ps.st           = ppst_pkg::PST_CRST;
                            end else begin
                                // field keeps last result after good detection
                                ps.cls  = filt_class(i_eng_rsp.cls_code, i_legacy5_select[p], ps.pwron);
                                cls_new = 1'b1;
                                if (ps.pwron) begin
                                    ps.fet = 1'b1;
                                    ps.pg  = 1'b0;
                                    ps.cnt = '0;
                                    ps.st  = ppst_pkg::PST_INRUSH;
                                end else begin
                                    ps.st = ppst_pkg::PST_OFF;
                                end
                            end
                        end
                    end
                    ppst_pkg::PST_CRST: begin
                        n.eng.cls_start = 1'b1;
                        n.eng.cls_pwron = ps.pwron;
                        n.eng.port      = p[1:0];
                        ps.st           = ppst_pkg::PST_CLS;
                    end
                    ppst_pkg::PST_INRUSH: begin
                        // power-good held low; faults ignored while charging
                        ps.pg = 1'b0;
                        if (i_host_power_off_request[p]) begin
                            turn_off = 1'b1;
                        end else if (tick) begin
                            if (r.port[p].cnt >= INRUSH_LAST) begin
                                // drain low at end of inrush
                                if (i_drain_low[p]) begin
                                    ps.pg = 1'b1;
                                    ps.st = ppst_pkg::PST_PGOOD;
                                end else begin
                                    turn_off = 1'b1;
                                end
                            end else begin
                                ps.cnt = r.port[p].cnt + 1'b1;
                            end
                        end
                    end
                    ppst_pkg::PST_PGOOD: begin
                        if (fault || i_host_power_off_request[p]) begin
                            turn_off = 1'b1;
                        end
                    end
                    default: begin
                        turn_off = 1'b1;
                    end
                endcase
            end
            if (turn_off) begin
                ps.fet   = 1'b0;
                ps.pg    = 1'b0;
                ps.pwron = 1'b0;
                ps.cnt   = '0;
                ps.st    = ppst_pkg::PST_OFF;
            end
            ps.mon    = (ps.st == ppst_pkg::PST_PGOOD);
            n.port[p] = ps;
            n.req[p]  = (ps.st == ppst_pkg::PST_WAIT) || (ps.st == ppst_pkg::PST_DET) ||
                        (ps.st == ppst_pkg::PST_CLS) || (ps.st == ppst_pkg::PST_CRST);
            // set wins over clear on every sticky bit
            n.cls_fin[p] = (r.cls_fin[p] & ~i_class_finished_clr[p]) | cls_new;
            n.fet_chg[p] = (r.fet_chg[p] & ~i_fet_chg_clr[p]) | (ps.fet != r.port[p].fet);
            n.pg_chg[p]  = (r.pg_chg[p] & ~i_pg_chg_clr[p]) | (ps.pg != r.port[p].pg);
            flags[ppst_pkg::PG_LSB + p]  = r.port[p].pg;
            flags[ppst_pkg::FET_LSB + p] = r.port[p].fet;
        end
        if (i_rd_en) begin
            n.rd_data = (i_rd_addr == ppst_pkg::ADDR_PORT_POWER_FLAGS) ? flags : ppst_pkg::UNMAPPED_READ;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    always_comb begin
        for (int p = 0; p < NP; p++) begin
            o_fet_on_flag[p]             = r.port[p].fet;
            o_port_powered_flag[p]       = r.port[p].pg;
            o_monitor_active[p]          = r.port[p].mon;
            o_class_result_field[4*p +: 4] = r.port[p].cls;
        end
    end

    assign o_eng_req             = r.eng;
    assign o_class_finished_flag = r.cls_fin;
    assign o_fet_chg             = r.fet_chg;
    assign o_pg_chg              = r.pg_chg;
    assign o_rd_data             = r.rd_data;
    assign o_rd_valid            = r.rd_valid;

endmodule

// File: dv/ppst_assertions.sv
// port-level and read-path checks of the power status tracker, bound into the top
`timescale 1ns/10ps
module ppst_assertions (
    input  wire logic                    i_core_clk,
    input  wire logic                    i_srst,
    input  wire logic                    i_rd_en,
    input  wire logic [7:0]              i_rd_addr,
    input  wire ppst_pkg::ppst_eng_rsp_s i_eng_rsp,
    input  wire ppst_pkg::ppst_eng_req_s o_eng_req,
    input  wire logic [3:0]              o_fet_on_flag,
    input  wire logic [3:0]              o_port_powered_flag,
    input  wire logic [3:0]              o_monitor_active,
    input  wire logic [3:0]              o_fet_chg,
    input  wire logic [3:0]              o_pg_chg,
    input  wire logic [7:0]              o_rd_data,
    input  wire logic                    o_rd_valid
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_srst);

    sequence s_mismatch;
        i_eng_rsp.cls_done && i_eng_rsp.cls_code == 4'hF;
    endsequence
    sequence s_retry;
        o_eng_req.cls_reset ##1 o_eng_req.cls_start;
    endsequence

    a_read_valid: assert property (o_rd_valid == $past(i_rd_en))
        else $error("read answer not one cycle after request");
    a_read_data: assert property (i_rd_en && i_rd_addr == 8'h10
        |=> o_rd_data == $past({o_port_powered_flag, o_fet_on_flag})) else $error("flag register content wrong");
    a_unmapped_zero: assert property (i_rd_en && i_rd_addr != 8'h10 |=> o_rd_data == 8'h00)
        else $error("unmapped read not zero");
    a_pg_needs_fet: assert property ((o_port_powered_flag & ~o_fet_on_flag) == 4'h0)
        else $error("power good without fet on");
    a_off_together: assert property (
        (($past(o_port_powered_flag) & ~o_port_powered_flag) & o_fet_on_flag) == 4'h0)
        else $error("power good cleared while fet stays on");
    a_fet_chg_mark: assert property (
        ((o_fet_on_flag ^ $past(o_fet_on_flag)) & ~o_fet_chg) == 4'h0) else $error("fet change not marked");
    a_pg_chg_mark: assert property (
        ((o_port_powered_flag ^ $past(o_port_powered_flag)) & ~o_pg_chg) == 4'h0)
        else $error("power good change not marked");
    a_fet_after_cls: assert property (|(o_fet_on_flag & ~$past(o_fet_on_flag)) |-> $past(i_eng_rsp.cls_done))
        else $error("fet on without class power-on answer");
    a_monitor_in_pg: assert property ((o_monitor_active & ~o_port_powered_flag) == 4'h0)
        else $error("monitoring outside power good");
    a_det_gates_cls: assert property (
        i_eng_rsp.det_done && !i_eng_rsp.valid_signature_result |=> !o_eng_req.cls_start [*3])
        else $error("class started after bad detection");
    a_mismatch_retry: assert property (s_mismatch |=> s_retry)
        else $error("no class reset and retry after mismatch");
endmodule
bind ppst_top ppst_assertions u_chk (.*);

// File: dv/ppst_eng_model.sv
// behavioural detect and class engine answering the tracker's requests
`timescale 1ns/10ps
module ppst_eng_model (
    input  wire logic                    i_core_clk,
    input  wire ppst_pkg::ppst_eng_req_s i_req,
    input  wire logic                    i_sig_ok,
    input  wire logic [3:0]              i_code,
    input  wire logic                    i_mis_once,
    input  wire logic [31:0]             i_delay,
    output ppst_pkg::ppst_eng_rsp_s      o_rsp
);
    logic is_det;
    logic mis_done;
    initial begin
        o_rsp = 7'h0A;
        mis_done = 1'b0;
    end
    always @(posedge i_core_clk) begin
        if (!i_mis_once) mis_done = 1'b0;
        if (i_req.det_start || i_req.cls_start) begin
            is_det = i_req.det_start;
            repeat (i_delay) @(posedge i_core_clk);
            #1;
            o_rsp.det_done = is_det;
            o_rsp.cls_done = !is_det;
            o_rsp.valid_signature_result = i_sig_ok;
            o_rsp.cls_code = (!is_det && i_mis_once && !mis_done) ? 4'hF : i_code;
            if (!is_det && i_mis_once) mis_done = 1'b1;
            @(posedge i_core_clk);
            #1;
            // released lines do not keep the answer
            o_rsp.det_done = 1'b0;
            o_rsp.cls_done = 1'b0;
            o_rsp.valid_signature_result = ~o_rsp.valid_signature_result;
            o_rsp.cls_code = ~o_rsp.cls_code;
        end
    end
endmodule

// File: dv/tb.sv
// self-checking bench for the four-port power status tracker
`timescale 1ns/10ps
module tb;
    logic [3:0]              i_host_power_on_request, i_host_power_off_request, i_probe_enable, i_legacy5_select;
    logic [3:0]              i_drain_low, i_current_limit_fault, i_power_cut_fault, i_disconnect;
    logic [3:0]              i_class_finished_clr, i_fet_chg_clr, i_pg_chg_clr, code;
    logic [3:0]              o_fet_on_flag, o_port_powered_flag, o_monitor_active, o_class_finished_flag;
    logic [3:0]              o_fet_chg, o_pg_chg;
    logic [7:0]              i_port_operating_mode_field, i_rd_addr, o_rd_data;
    logic [15:0]             o_class_result_field;
    logic                    i_core_clk, i_srst, i_rd_en, o_rd_valid, sig_ok, mis_once;
    ppst_pkg::ppst_eng_rsp_s i_eng_rsp;
    ppst_pkg::ppst_eng_req_s o_eng_req;
    int                      delay, n_fail, total_checks, cyc_cnt, i;
    logic [11:0]             tbl [3] = '{12'hD04, 12'hD1D, 12'hC04};

    ppst_top #(.TICK_CYCLES(4), .inrush_interval(2)) dut (.*);
    ppst_eng_model far (.i_core_clk(i_core_clk), .i_req(o_eng_req), .i_sig_ok(sig_ok), .i_code(code),
                        .i_mis_once(mis_once), .i_delay(delay), .o_rsp(i_eng_rsp));

    always #10 i_core_clk = ~i_core_clk;

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // hang guard, run needs well under a thousand cycles
    always @(posedge i_core_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 3000) begin
            n_fail++;
            complete_run();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        i_rd_en = 1'b1;
        i_rd_addr = addr;
        cyc(1);
        i_rd_en = 1'b0;
        chk("rd_valid", 8'h01, 8'(o_rd_valid));
        chk("rd_data", exp, o_rd_data);
    endtask
    task automatic wait_bit(input int kind, input int p);
        logic b;
        for (int n = 0; n < 200; n++) begin
            b = (kind == 0) ? o_fet_on_flag[p] : (kind == 1) ? o_port_powered_flag[p] : o_class_finished_flag[p];
            if (b === 1'b1) break;
            cyc(1);
        end
    endtask
    task automatic pwr_on(input int p);
        i_host_power_on_request[p] = 1'b1;
        cyc(1);
        i_host_power_on_request[p] = 1'b0;
    endtask

    initial begin
        {i_host_power_on_request, i_host_power_off_request, i_probe_enable, i_legacy5_select} = '0;
        {i_current_limit_fault, i_power_cut_fault, i_disconnect, i_class_finished_clr} = '0;
        {i_fet_chg_clr, i_pg_chg_clr, i_rd_en, i_rd_addr, i_port_operating_mode_field} = '0;
        {i_core_clk, i_srst, sig_ok, mis_once, code, i_drain_low} = {3'b011, 5'h04, 4'hF};
        {delay, n_fail, total_checks, cyc_cnt} = {32'd1, 96'd0};
        cyc(8);
        i_srst = 1'b0;
        rd(8'h10, 8'h00);
        cyc(1);
        rd(8'h11, 8'h00);
        $display("test reads done");
        i_port_operating_mode_field = 8'hAA;
        pwr_on(0);
        wait_bit(0, 0);
        chk("fet", 8'h01, 8'(o_fet_on_flag));
        chk("pg in inrush", 8'h00, 8'(o_port_powered_flag));
        chk("class", 8'h04, 8'(o_class_result_field[3:0]));
        wait_bit(1, 0);
        chk("pg", 8'h01, 8'(o_port_powered_flag));
        chk("monitor", 8'h01, 8'(o_monitor_active));
        rd(8'h10, 8'h11);
        pwr_on(1);
        wait_bit(0, 1);
        {i_current_limit_fault[1], i_disconnect[1]} = 2'b11;
        cyc(2);
        {i_current_limit_fault[1], i_disconnect[1]} = 2'b00;
        chk("fault in inrush", 8'h03, 8'(o_fet_on_flag));
        wait_bit(1, 1);
        rd(8'h10, 8'h33);
        $display("test power_up done");
        {i_fet_chg_clr, i_pg_chg_clr} = 8'hFF;
        cyc(1);
        {i_fet_chg_clr, i_pg_chg_clr} = 8'h00;
        chk("fet_chg clr", 8'h00, 8'(o_fet_chg));
        i_power_cut_fault[0] = 1'b1;
        cyc(1);
        i_power_cut_fault[0] = 1'b0;
        cyc(1);
        rd(8'h10, 8'h22);
        chk("fet_chg", 8'h01, 8'(o_fet_chg));
        chk("pg_chg", 8'h01, 8'(o_pg_chg));
        $display("test turn_off done");
        {mis_once, delay} = {1'b1, 32'd5};
        i_drain_low[2] = 1'b0;
        pwr_on(2);
        wait_bit(0, 2);
        mis_once = 1'b0;
        chk("retry class", 8'h04, 8'(o_class_result_field[11:8]));
        cyc(12);
        chk("drain high", 8'h02, 8'(o_fet_on_flag));
        i_host_power_off_request[1] = 1'b1;
        cyc(1);
        i_host_power_off_request[1] = 1'b0;
        chk("power off", 8'h00, {o_fet_on_flag, o_port_powered_flag});
        $display("test mismatch done");
        {sig_ok, delay} = {1'b0, 32'd1};
        i_probe_enable[3] = 1'b1;
        cyc(30);
        chk("no class", 8'h00, 8'(o_class_finished_flag[3]));
        // let a detect already under way end on a bad signature first
        i_probe_enable[3] = 1'b0;
        cyc(10);
        sig_ok = 1'b1;
        for (i = 0; i < 3; i++) begin
            code = tbl[i][11:8];
            i_legacy5_select[3] = tbl[i][4];
            i_class_finished_clr[3] = 1'b1;
            cyc(1);
            {i_class_finished_clr[3], i_probe_enable[3]} = 2'b01;
            wait_bit(2, 3);
            i_probe_enable[3] = 1'b0;
            chk("probe class", 8'(tbl[i][3:0]), 8'(o_class_result_field[15:12]));
            chk("probe fet", 8'h00, 8'(o_fet_on_flag[3]));
            cyc(10);
        end
        $display("test probe done");
        i_port_operating_mode_field[7:6] = 2'b01;
        pwr_on(3);
        cyc(30);
        chk("manual", 8'h00, 8'(o_fet_on_flag[3]));
        i_port_operating_mode_field[7:6] = 2'b11;
        wait_bit(0, 3);
        chk("auto", 8'h01, 8'(o_fet_on_flag[3]));
        i_port_operating_mode_field[7:6] = 2'b00;
        cyc(2);
        chk("shutdown", 8'h00, {o_fet_on_flag[3], o_port_powered_flag[3], o_class_result_field[15:12]});
        $display("test modes done");
        complete_run();
    end
endmodule
